//--- common/mev_pkg.sv
// Purpose: Constants, register map and field layout of the motion event
//          detector.
// Assumes: 20 MHz system clock and 8-bit software register port.
// Notes:   Rules carried out by the detector are listed below.
// Function
// R1: Clear any-motion status after programmed count of quiet samples.
// R2: Any-motion when any axis sample delta exceeds 15-bit motion level.
// R3: Shake condition when any axis sample delta exceeds shake level.
// R4: Shake level low byte at 0x46, upper byte at 0x47 to bit 15.
// R5: Shake condition advances shake counter and starts peak width measure.
// R6: Peak wider than span limit advances shake counter while timing.
// R7: After shake ends, time the gap and keep advancing counter.
// R8: Counter advances whenever peak or gap span limit is exceeded.
// R9: Shake interrupt decided from level, span limit and count limit.
// R10: Count above 3-bit count limit sets shake flag and restarts.
// R11: Span limit 12 bits at 0x48 and 0x49[3:0]; count at 0x49[6:4].
// R12: Tilt-35 hold and temporary latch timed by internal 10 Hz tick.
// R13: Timer byte 0x4A: latch enable 7, period 6:4, tilt code 2:0.
// R14: Tilt-35 hold is 1.6 s plus 0.2 s per code step.
// R15: Held tilt-35 position sets status bit 4.
// R16: Latch period 200 ms doubling per code to 6400 ms; 110, 111 reserved.
// R17: Temporary latch only active while its enable bit is one.
// R18: Enabled latch holds pin after event and re-arms when period ends.
package mev_pkg;

	localparam int MEV_CLK_HZ = 20_000_000;
	localparam int MEV_SLOW_HZ = 10;
	localparam logic [21:0] MEV_TICK_CYCLES = 22'(MEV_CLK_HZ / MEV_SLOW_HZ);
	localparam int MEV_TICK_MS = 1000 / MEV_SLOW_HZ;

	localparam int MEV_TILT_BASE_MS = 1600;
	localparam int MEV_TILT_STEP_MS = 200;
	localparam logic [4:0] MEV_TILT_BASE_TICKS =
		5'(MEV_TILT_BASE_MS / MEV_TICK_MS);
	localparam logic [4:0] MEV_TILT_STEP_TICKS =
		5'(MEV_TILT_STEP_MS / MEV_TICK_MS);
	localparam int MEV_LATCH_BASE_MS = 200;
	localparam logic [6:0] MEV_LATCH_BASE_TICKS =
		7'(MEV_LATCH_BASE_MS / MEV_TICK_MS);
	localparam logic [2:0] MEV_LATCH_CODE_MAX = 3'h5;

	localparam logic [7:0] MEV_ADDR_STATUS = 8'h14;
	localparam logic [7:0] MEV_ADDR_MASK = 8'h15;
	localparam logic [7:0] MEV_ADDR_INCL_LOW = 8'h40;
	localparam logic [7:0] MEV_ADDR_INCL_HIGH = 8'h41;
	localparam logic [7:0] MEV_ADDR_MOTION_LOW = 8'h43;
	localparam logic [7:0] MEV_ADDR_MOTION_HIGH = 8'h44;
	localparam logic [7:0] MEV_ADDR_QUIET = 8'h45;
	localparam logic [7:0] MEV_ADDR_SHAKE_LOW = 8'h46;
	localparam logic [7:0] MEV_ADDR_SHAKE_HIGH = 8'h47;
	localparam logic [7:0] MEV_ADDR_SPAN_LOW = 8'h48;
	localparam logic [7:0] MEV_ADDR_SPAN_HIGH = 8'h49;
	localparam logic [7:0] MEV_ADDR_TIMER = 8'h4A;

	localparam logic [7:0] MEV_RESET_BYTE = 8'h00;
	localparam int MEV_ST_MOTION = 2;
	localparam int MEV_ST_SHAKE = 3;
	localparam int MEV_ST_TILT = 4;
	localparam logic [7:0] MEV_STATUS_USED = 8'h1C;
	localparam logic [7:0] MEV_HIGH15_MASK = 8'h7F;
	localparam logic [7:0] MEV_TIMER_MASK = 8'hF7;
	localparam int MEV_TM_LATCH_EN = 7;

	typedef enum logic [1:0] {
		MEV_SHK_IDLE = 2'b00,
		MEV_SHK_PEAK = 2'b01,
		MEV_SHK_GAP = 2'b10
	} mev_shake_e;

endpackage

//--- rtl/mev_top.sv
// Purpose: Any-motion, shake and tilt-35 event logic with interrupt pin.
// Assumes: Samples arrive from logic on clk; registers reached by a plain
//          address/strobe port with read data one cycle later.
// Notes:   Quiet time and shake spans are counted in samples.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module mev_top
	import mev_pkg::*;
#(
	parameter logic [21:0] TICK_CYCLES = MEV_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic sample_valid,
	input wire logic signed [15:0] sample_x,
	input wire logic signed [15:0] sample_y,
	input wire logic signed [15:0] sample_z,
	output logic int_out
);

	function automatic logic [16:0] abs_delta(input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		abs_delta = d[16] ? 17'(-d) : 17'(d);
	endfunction

	function automatic logic [16:0] abs_val(input logic signed [15:0] a);
		abs_val = a[15] ? 17'(-17'(a)) : 17'(a);
	endfunction

	logic rst_meta_reg, rst_n_reg;
	logic [7:0] incl_low_reg, incl_high_reg, motion_low_reg, motion_high_reg;
	logic [7:0] quiet_reg, shake_low_reg, shake_high_reg;
	logic [7:0] span_low_reg, span_high_reg, timer_reg;
	logic [7:0] status_reg, mask_reg, rdata_reg, rdata_next;
	logic [7:0] w1c, set_vec;
	logic signed [15:0] prev_x_reg, prev_y_reg, prev_z_reg;
	logic have_prev_reg;
	logic [16:0] dx, dy, dz, motion_lvl, shake_lvl, incl_lvl;
	logic motion_cond, shake_cond, step;
	logic motion_set, quiet_clr, tilt_set;
	logic [8:0] quiet_cnt_reg;
	logic [11:0] span_limit, width_reg;
	logic [2:0] count_limit, shake_cnt_reg;
	mev_shake_e shk_reg;
	logic [21:0] div_reg;
	logic tick;
	logic tilt_cond_reg, tilt_done_reg;
	logic [4:0] tilt_cnt_reg, tilt_need;
	logic [6:0] latch_cnt_reg, latch_period;
	logic [2:0] latch_code;
	logic latch_en, int_reg, int_next;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// Configuration registers; reserved bits are stored as zero.
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			incl_low_reg <= MEV_RESET_BYTE;
			incl_high_reg <= MEV_RESET_BYTE;
			motion_low_reg <= MEV_RESET_BYTE;
			motion_high_reg <= MEV_RESET_BYTE;
			quiet_reg <= MEV_RESET_BYTE;
			shake_low_reg <= MEV_RESET_BYTE;
			shake_high_reg <= MEV_RESET_BYTE;
			span_low_reg <= MEV_RESET_BYTE;
			span_high_reg <= MEV_RESET_BYTE;
			timer_reg <= MEV_RESET_BYTE;
			mask_reg <= MEV_RESET_BYTE;
		end else if (wr_en) begin
			case (addr)
				MEV_ADDR_INCL_LOW: incl_low_reg <= wdata;
				MEV_ADDR_INCL_HIGH: incl_high_reg <= wdata & MEV_HIGH15_MASK;
				MEV_ADDR_MOTION_LOW: motion_low_reg <= wdata;
				MEV_ADDR_MOTION_HIGH: motion_high_reg <= wdata & MEV_HIGH15_MASK;
				MEV_ADDR_QUIET: quiet_reg <= wdata;
				MEV_ADDR_SHAKE_LOW: shake_low_reg <= wdata; // R4
				MEV_ADDR_SHAKE_HIGH: shake_high_reg <= wdata; // R4
				MEV_ADDR_SPAN_LOW: span_low_reg <= wdata; // R11
				MEV_ADDR_SPAN_HIGH: span_high_reg <= wdata & MEV_HIGH15_MASK; // R11
				MEV_ADDR_TIMER: timer_reg <= wdata & MEV_TIMER_MASK; // R13
				MEV_ADDR_MASK: mask_reg <= wdata & MEV_STATUS_USED;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (addr)
			MEV_ADDR_STATUS: rdata_next = status_reg;
			MEV_ADDR_MASK: rdata_next = mask_reg;
			MEV_ADDR_INCL_LOW: rdata_next = incl_low_reg;
			MEV_ADDR_INCL_HIGH: rdata_next = incl_high_reg;
			MEV_ADDR_MOTION_LOW: rdata_next = motion_low_reg;
			MEV_ADDR_MOTION_HIGH: rdata_next = motion_high_reg;
			MEV_ADDR_QUIET: rdata_next = quiet_reg;
			MEV_ADDR_SHAKE_LOW: rdata_next = shake_low_reg;
			MEV_ADDR_SHAKE_HIGH: rdata_next = shake_high_reg;
			MEV_ADDR_SPAN_LOW: rdata_next = span_low_reg;
			MEV_ADDR_SPAN_HIGH: rdata_next = span_high_reg;
			MEV_ADDR_TIMER: rdata_next = timer_reg;
			default: rdata_next = MEV_RESET_BYTE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			rdata_reg <= MEV_RESET_BYTE;
		else if (rd_en)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= MEV_RESET_BYTE;
	end
	assign rdata = rdata_reg;

	// Sample history: the first sample after reset only primes it.
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			prev_x_reg <= '0;
			prev_y_reg <= '0;
			prev_z_reg <= '0;
			have_prev_reg <= 1'b0;
			tilt_cond_reg <= 1'b0;
		end else if (sample_valid) begin
			prev_x_reg <= sample_x;
			prev_y_reg <= sample_y;
			prev_z_reg <= sample_z;
			have_prev_reg <= 1'b1;
			tilt_cond_reg <= abs_val(sample_x) > incl_lvl
				|| abs_val(sample_y) > incl_lvl;
		end
	end

	assign dx = abs_delta(sample_x, prev_x_reg);
	assign dy = abs_delta(sample_y, prev_y_reg);
	assign dz = abs_delta(sample_z, prev_z_reg);
	assign motion_lvl = {2'b00, motion_high_reg[6:0], motion_low_reg};
	assign shake_lvl = {1'b0, shake_high_reg, shake_low_reg}; // R4
	assign incl_lvl = {2'b00, incl_high_reg[6:0], incl_low_reg};
	assign span_limit = {span_high_reg[3:0], span_low_reg}; // R11
	assign count_limit = span_high_reg[6:4]; // R11
	assign step = sample_valid && have_prev_reg;
	assign motion_cond = dx > motion_lvl || dy > motion_lvl
		|| dz > motion_lvl; // R2
	assign shake_cond = dx > shake_lvl || dy > shake_lvl
		|| dz > shake_lvl; // R3
	assign motion_set = step && motion_cond; // R2
	assign quiet_clr = step && !motion_cond && status_reg[MEV_ST_MOTION]
		&& (quiet_cnt_reg + 9'h001) >= {1'b0, quiet_reg}; // R1

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			quiet_cnt_reg <= '0;
		else if (motion_set || quiet_clr)
			quiet_cnt_reg <= '0;
		else if (step && status_reg[MEV_ST_MOTION])
			quiet_cnt_reg <= quiet_cnt_reg + 9'h001; // R1
	end

	// Shake sequencing: the peak that leaves idle and each span overrun is a count.
	logic bump, shake_hit;
	always_comb begin
		bump = 1'b0;
		if (step) begin
			case (shk_reg)
				MEV_SHK_IDLE: bump = shake_cond; // R5
				MEV_SHK_PEAK: bump = shake_cond && width_reg >= span_limit; // R6
				MEV_SHK_GAP: bump = !shake_cond && width_reg >= span_limit; // R7
				default: bump = 1'b0;
			endcase
		end
	end
	assign shake_hit = bump && shake_cnt_reg >= count_limit; // R10

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			shk_reg <= MEV_SHK_IDLE;
			width_reg <= '0;
			shake_cnt_reg <= '0;
		end else if (step) begin
			if (shake_hit)
				shake_cnt_reg <= '0; // R10
			else if (bump)
				shake_cnt_reg <= shake_cnt_reg + 3'h1; // R8
			case (shk_reg)
				MEV_SHK_IDLE: begin
					width_reg <= '0;
					if (shake_cond)
						shk_reg <= MEV_SHK_PEAK; // R5
				end
				MEV_SHK_PEAK: begin
					if (!shake_cond) begin
						shk_reg <= MEV_SHK_GAP; // R7
						width_reg <= '0;
					end else if (bump)
						width_reg <= '0; // R6
					else
						width_reg <= width_reg + 12'h001;
				end
				MEV_SHK_GAP: begin
					if (shake_cond) begin
						shk_reg <= MEV_SHK_PEAK;
						width_reg <= '0;
					end else if (bump)
						width_reg <= '0; // R7
					else
						width_reg <= width_reg + 12'h001;
				end
				default: shk_reg <= MEV_SHK_IDLE;
			endcase
		end
	end

	// Slow timebase; the first tick after a start may come early by up
	// to one period, which the hold and latch times tolerate.
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			div_reg <= '0;
			tick <= 1'b0;
		end else if (div_reg >= TICK_CYCLES - 22'h000001) begin
			div_reg <= '0;
			tick <= 1'b1; // R12
		end else begin
			div_reg <= div_reg + 22'h000001;
			tick <= 1'b0;
		end
	end

	assign tilt_need = MEV_TILT_BASE_TICKS
		+ 5'(timer_reg[2:0] * MEV_TILT_STEP_TICKS); // R14
	assign tilt_set = tick && tilt_cond_reg && !tilt_done_reg
		&& tilt_cnt_reg + 5'h01 >= tilt_need; // R15

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			tilt_cnt_reg <= '0;
			tilt_done_reg <= 1'b0;
		end else if (!tilt_cond_reg) begin
			tilt_cnt_reg <= '0;
			tilt_done_reg <= 1'b0;
		end else if (tilt_set)
			tilt_done_reg <= 1'b1;
		else if (tick && !tilt_done_reg)
			tilt_cnt_reg <= tilt_cnt_reg + 5'h01; // R12
	end

	always_comb begin
		set_vec = '0;
		set_vec[MEV_ST_MOTION] = motion_set;
		set_vec[MEV_ST_SHAKE] = shake_hit; // R9
		set_vec[MEV_ST_TILT] = tilt_set;
		w1c = (wr_en && addr == MEV_ADDR_STATUS) ? wdata : '0;
	end

	// Hardware sets beat any clear arriving in the same cycle.
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			status_reg <= MEV_RESET_BYTE;
		else begin
			status_reg <= ((status_reg & ~w1c
				& ~(8'(quiet_clr) << MEV_ST_MOTION)) | set_vec) // R1
				& MEV_STATUS_USED;
		end
	end

	// Reserved period codes are clamped to the longest legal period.
	assign latch_code = timer_reg[6:4] > MEV_LATCH_CODE_MAX
		? MEV_LATCH_CODE_MAX : timer_reg[6:4]; // R16
	assign latch_period = MEV_LATCH_BASE_TICKS << latch_code; // R16
	assign latch_en = timer_reg[MEV_TM_LATCH_EN]; // R17

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			latch_cnt_reg <= '0;
		else if (!latch_en)
			latch_cnt_reg <= '0; // R17
		else if ((set_vec & mask_reg) != 8'h00)
			latch_cnt_reg <= latch_period; // R18
		else if (tick && latch_cnt_reg != 7'h00)
			latch_cnt_reg <= latch_cnt_reg - 7'h01; // R18
	end

	assign int_next = latch_en ? latch_cnt_reg != 7'h00
		: (status_reg & mask_reg) != 8'h00;

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			int_reg <= 1'b0;
		else
			int_reg <= int_next; // R18
	end
	assign int_out = int_reg;

	motion_set_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R2
		motion_set |=> status_reg[MEV_ST_MOTION])
		else $error("Motion event did not set status.");
	quiet_clear_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R1
		quiet_clr |=> !status_reg[MEV_ST_MOTION] && quiet_cnt_reg == 9'h000)
		else $error("Quiet time did not clear motion status.");
	shake_flag_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R10
		shake_hit |=> status_reg[MEV_ST_SHAKE] && shake_cnt_reg == 3'h0)
		else $error("Shake flag or restart missing.");
	shake_start_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R5
		step && shk_reg == MEV_SHK_IDLE && shake_cond && !shake_hit
		|=> shk_reg == MEV_SHK_PEAK
		&& shake_cnt_reg == $past(shake_cnt_reg) + 3'h1)
		else $error("Shake start did not advance counter.");
	gap_count_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R7
		step && shk_reg == MEV_SHK_GAP && !shake_cond
		&& width_reg >= span_limit && !shake_hit
		|=> shake_cnt_reg == $past(shake_cnt_reg) + 3'h1
		&& width_reg == 12'h000)
		else $error("Gap span overrun did not advance counter.");
	tick_space_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R12
		tick |=> !tick)
		else $error("Slow tick wider than one cycle.");
	tilt_set_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R15
		tilt_set |=> status_reg[MEV_ST_TILT] && tilt_done_reg)
		else $error("Tilt hold did not set status.");
	latch_off_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R17
		!latch_en && (status_reg & mask_reg) == 8'h00 |=> !int_out)
		else $error("Pin high with latch off and nothing pending.");
	latch_load_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R18
		latch_en && (set_vec & mask_reg) != 8'h00 && !(wr_en
		&& addr == MEV_ADDR_TIMER) |=> latch_cnt_reg == latch_period ##1 int_out)
		else $error("Latch not armed after event.");
	latch_release_a: assert property (@(posedge clk) disable iff (!rst_n_reg) // R18
		latch_en && tick && latch_cnt_reg == 7'h01
		&& (set_vec & mask_reg) == 8'h00 && !(wr_en && addr == MEV_ADDR_TIMER)
		|=> latch_cnt_reg == 7'h00 ##1 !int_out)
		else $error("Latch did not release when its period ended.");
	read_data_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
		rd_en && addr == MEV_ADDR_STATUS |=> rdata == $past(status_reg))
		else $error("Status read data wrong.");

endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the motion event detector registers,
//          any-motion, shake, tilt-35 timing and the interrupt pin latch.
// Assumes: TICK_CYCLES is cut to 20 so slow-tick timing stays short.
// Notes:   Windows on tick timing allow for the unknown tick phase.
`timescale 1ns/1ns
module tb_top
	import mev_pkg::*;
;

	localparam logic [21:0] TICKS = 22'h000014;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rdata;
	logic sample_valid = 1'b0;
	logic signed [15:0] sample_x = 16'sh0000;
	logic signed [15:0] sample_y = 16'sh0000;
	logic signed [15:0] sample_z = 16'sh0000;
	logic int_out;
	int errors = 0;
	int checks = 0;
	logic [7:0] got;

	mev_top #(.TICK_CYCLES(TICKS)) dut (
		.clk(clk),
		.arst_n(arst_n),
		.addr(addr),
		.wdata(wdata),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rdata(rdata),
		.sample_valid(sample_valid),
		.sample_x(sample_x),
		.sample_y(sample_y),
		.sample_z(sample_z),
		.int_out(int_out)
	);

	always #25 clk = ~clk;

	task automatic summarize();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] seen);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// Read data is taken just after the edge that follows the strobe.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic rchk(input string name, input logic [7:0] a,
		input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(name, exp, d);
	endtask

	task automatic smp(input logic signed [15:0] x);
		@(posedge clk);
		sample_valid <= 1'b1;
		sample_x <= x;
		sample_y <= 16'sh0000;
		sample_z <= 16'sh0000;
		@(posedge clk);
		sample_valid <= 1'b0;
	endtask

	task automatic pin(input logic exp);
		chk("int_out", {7'h00, exp}, {7'h00, int_out});
	endtask

	// Bits that hold storage after writing all ones; reserved bits read 0.
	function automatic logic [7:0] keep(input logic [7:0] a);
		case (a)
			MEV_ADDR_MASK: keep = MEV_STATUS_USED;
			MEV_ADDR_INCL_HIGH, MEV_ADDR_MOTION_HIGH: keep = 8'h7F;
			MEV_ADDR_SPAN_HIGH: keep = 8'h7F;
			MEV_ADDR_TIMER: keep = 8'hF7;
			default: keep = 8'hFF;
		endcase
	endfunction

	initial begin
		#1000000;
		errors++;
		$display("[ERR] watchdog expected done seen hang");
		summarize();
	end

	initial begin
		logic [7:0] regs[11] = '{8'h15, 8'h40, 8'h41, 8'h43, 8'h44, 8'h45,
			8'h46, 8'h47, 8'h48, 8'h49, 8'h4A};
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		pin(1'b0);
		rchk("status", MEV_ADDR_STATUS, 8'h00);
		foreach (regs[i]) rchk("reset", regs[i], MEV_RESET_BYTE);
		foreach (regs[i]) wr(regs[i], 8'hFF);
		foreach (regs[i]) rchk("fill", regs[i], keep(regs[i]));
		wr(8'h50, 8'hFF);
		rchk("unmapped", 8'h50, 8'h00);
		foreach (regs[i]) wr(regs[i], 8'h00);
		wr(MEV_ADDR_INCL_LOW, 8'hFF);
		wr(MEV_ADDR_INCL_HIGH, 8'h7F);
		// A high shake level keeps shake events out of the motion checks.
		wr(MEV_ADDR_SHAKE_HIGH, 8'h7F);
		// Any-motion: strict compare, then clear after three quiet samples.
		wr(MEV_ADDR_MOTION_LOW, 8'h64);
		wr(MEV_ADDR_QUIET, 8'h03);
		smp(16'sd0);
		smp(16'sd100);
		rchk("motion_eq", MEV_ADDR_STATUS, 8'h00);
		smp(16'sd201);
		rchk("motion_set", MEV_ADDR_STATUS, 8'h04);
		smp(16'sd201);
		smp(16'sd201);
		rchk("quiet_two", MEV_ADDR_STATUS, 8'h04);
		smp(16'sd201);
		rchk("quiet_three", MEV_ADDR_STATUS, 8'h00);
		// Tilt-35 hold with code 1 is 18 ticks of 20 cycles.
		wr(MEV_ADDR_INCL_HIGH, 8'h00);
		wr(MEV_ADDR_INCL_LOW, 8'h64);
		wr(MEV_ADDR_TIMER, 8'h01);
		smp(16'sd201);
		repeat (320) @(posedge clk);
		rd(MEV_ADDR_STATUS, got);
		chk("tilt_early", 8'h00, got & 8'h10);
		repeat (100) @(posedge clk);
		rd(MEV_ADDR_STATUS, got);
		chk("tilt_held", 8'h10, got & 8'h10);
		wr(MEV_ADDR_STATUS, 8'h1C);
		// Latch on with code 1: pin drops after four ticks despite status.
		wr(MEV_ADDR_MASK, 8'h04);
		wr(MEV_ADDR_TIMER, 8'h90);
		smp(16'sd0);
		repeat (3) @(posedge clk);
		pin(1'b1);
		repeat (50) @(posedge clk);
		pin(1'b1);
		repeat (50) @(posedge clk);
		pin(1'b0);
		rd(MEV_ADDR_STATUS, got);
		chk("latch_status", 8'h04, got & 8'h04);
		wr(MEV_ADDR_TIMER, 8'h00);
		repeat (3) @(posedge clk);
		pin(1'b1);
		wr(MEV_ADDR_STATUS, 8'h04);
		repeat (3) @(posedge clk);
		pin(1'b0);
		rd(MEV_ADDR_STATUS, got);
		chk("w1c", 8'h00, got & 8'h04);
		// Shake: level 50, span 2, count limit 2.
		wr(MEV_ADDR_SHAKE_LOW, 8'h32);
		wr(MEV_ADDR_SHAKE_HIGH, 8'h00);
		wr(MEV_ADDR_SPAN_LOW, 8'h02);
		wr(MEV_ADDR_SPAN_HIGH, 8'h20);
		smp(16'sd100);
		rd(MEV_ADDR_STATUS, got);
		chk("shake_one", 8'h00, got & 8'h08);
		for (int i = 0; i < 12; i++) smp((i % 2 == 0) ? 16'sd0 : 16'sd100);
		rd(MEV_ADDR_STATUS, got);
		chk("shake_set", 8'h08, got & 8'h08);
		// Steady samples end the peak; the fourth gap sample overruns span.
		wr(MEV_ADDR_STATUS, 8'h08);
		repeat (3) smp(16'sd100);
		rd(MEV_ADDR_STATUS, got);
		chk("gap_wait", 8'h00, got & 8'h08);
		smp(16'sd100);
		rd(MEV_ADDR_STATUS, got);
		chk("gap_set", 8'h08, got & 8'h08);
		repeat (3) smp(16'sd100);
		summarize();
	end
endmodule
